// ==== dv/svm_map_props.sv ====
// assertion checker on the ports of the supervisor memory map
`timescale 1ns/1ps
`default_nettype none
module svm_map_props
#(
    parameter NV_WRITE_CYCLES = 20
)
(
    input wire clk,
    input wire resetn,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire stop_cond,
    input wire nv_busy_reg,
    input wire [7:0] rdata_reg,
    input wire rd_valid_reg,
    input wire [3:0] pullup_en_reg,
    input wire [3:0] pulldown_en_reg,
    input wire rst_out_reg,
    input wire rst_oe_n_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [31:0] busy_cnt_reg;
    // counts the sampled busy cycles of one programming cycle
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= nv_busy_reg ? busy_cnt_reg + 32'h1 : 32'h0;
    end
    sequence s_softrst_req;
        wr_stb && addr == 8'hf9 && wdata[3] && !nv_busy_reg;
    endsequence
    sequence s_rst_held;
        !rst_oe_n_reg [*8];
    endsequence
    a_read_latency: assert property (rd_stb |-> ##2 rd_valid_reg)
        else $error("read answer missing two cycles after strobe");
    a_valid_cause: assert property (rd_valid_reg |-> $past(rd_stb, 2))
        else $error("read answer without a strobe");
    a_rsv_zero: assert property (rd_stb && addr >= 8'h40
        && addr <= 8'hef |-> ##2 rdata_reg == 8'h00)
        else $error("reserved location read nonzero");
    a_status_upper: assert property (rd_stb && addr == 8'hf8
        |-> ##2 rdata_reg[7:4] == 4'h0)
        else $error("pin status upper bits nonzero");
    a_softrst_drive: assert property (s_softrst_req
        |-> ##2 s_rst_held)
        else $error("soft reset did not hold the reset pin low");
    a_rst_data_low: assert property (rst_out_reg == 1'b0)
        else $error("reset pin data not low");
    a_busy_start: assert property ($rose(nv_busy_reg)
        |-> $past(stop_cond))
        else $error("programming began without a stop");
    a_busy_len: assert property ($fell(nv_busy_reg)
        |-> busy_cnt_reg == NV_WRITE_CYCLES)
        else $error("programming cycle length wrong");
    a_pullup_set: assert property (wr_stb && addr == 8'hf0
        && !nv_busy_reg && wdata[0] |-> ##2 pullup_en_reg[0])
        else $error("pull-up of pin 0 not enabled");
    a_pulldown_on: assert property (wr_stb && addr == 8'hf4
        && !nv_busy_reg && !wdata[0] |-> ##2 pulldown_en_reg[3])
        else $error("pull-down of pin 3 not enabled");
endmodule
`default_nettype wire

// ==== dv/svm_map_tb.sv ====
// self-checking bench for the supervisor memory map
`timescale 1ns/1ps
`default_nettype none
module svm_map_tb;
    localparam NV = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic stop_cond = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [3:0] ext_drive = 4'h2;
    logic sup_ready = 1'b1;
    logic sup_trip = 1'b0;
    wire [3:0] pins, pu, pd;
    wire [7:0] rdata;
    wire [1:0] dly;
    wire rd_valid, busy, rst_out, rst_oe_n;
    int fail_count = 0;
    int cmp_count = 0;
    logic [15:0] rst_tab [11] = '{16'hf000, 16'hf103, 16'hf200, 16'hf300,
        16'hf401, 16'hf701, 16'hfa00, 16'hff00, 16'h4000, 16'hef00, 16'hf980};
    always #25 clk = ~clk;
    svm_map #(.NV_WRITE_CYCLES(NV)) i_svm_map (.clk(clk), .resetn(resetn),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr), .wdata(wdata),
        .stop_cond(stop_cond), .supply_ready(sup_ready),
        .supply_trip(sup_trip),
        .gp_pin_in(pins), .rdata_reg(rdata), .rd_valid_reg(rd_valid),
        .nv_busy_reg(busy), .pullup_en_reg(pu), .pulldown_en_reg(pd),
        .reset_delay_sel_reg(dly), .rst_out_reg(rst_out),
        .rst_oe_n_reg(rst_oe_n));
    svm_pins i_svm_pins (.pullup_en(pu), .pulldown_en(pd),
        .ext_drive(ext_drive), .pin_level(pins));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_stb = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_stb = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd_stb = 1'b1;
        addr = a;
        @(negedge clk);
        rd_stb = 1'b0;
        // answer stands for one cycle only, between the next two edges
        @(negedge clk);
        chk({7'h00, rd_valid}, 8'h01);
        chk(rdata, exp);
    endtask
    // stop pulse, then measure how long programming runs
    task automatic prog(input logic exp);
        int n;
        @(negedge clk);
        stop_cond = 1'b1;
        @(negedge clk);
        stop_cond = 1'b0;
        // busy rose at the edge that took the stop
        chk({7'h00, busy}, {7'h00, exp});
        n = 0;
        while (busy === 1'b1 && n < NV + 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (exp)
            chk(8'(n), 8'(NV));
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        chk({6'h00, dly}, 8'h03);
        chk({pu, pd}, 8'h00);
        foreach (rst_tab[i])
            rd(rst_tab[i][15:8], rst_tab[i][7:0]);
        $display("test reset values done");
        wr(8'hf9, 8'h10);
        for (int i = 0; i < 6; i++)
            wr(8'(8'hfa + i), 8'(8'h11 * i));
        wr(8'hf0, 8'ha5);
        wr(8'hf1, 8'h02);
        wr(8'hf4, 8'h00);
        wr(8'hf3, 8'hc3);
        prog(1'b0);
        for (int i = 0; i < 6; i++)
            rd(8'(8'hfa + i), 8'(8'h11 * i));
        rd(8'hf0, 8'ha5);
        rd(8'hf3, 8'hc3);
        rd(8'hf8, 8'h07);
        chk({pu, pd}, 8'h58);
        chk({6'h00, dly}, 8'h02);
        $display("test volatile writes done");
        wr(8'h80, 8'hff);
        wr(8'hf8, 8'hff);
        wr(8'hf9, 8'hd7);
        rd(8'h80, 8'h00);
        rd(8'hf8, 8'h07);
        rd(8'hf9, 8'h90);
        $display("test refused writes done");
        wr(8'h3f, 8'h3c);
        prog(1'b1);
        rd(8'h3f, 8'h3c);
        wr(8'hf9, 8'h00);
        wr(8'hf2, 8'h5a);
        prog(1'b1);
        rd(8'hf2, 8'h5a);
        $display("test programming done");
        wr(8'hf9, 8'h08);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, rst_oe_n}, 8'h00);
        rd(8'hf9, 8'ha8);
        repeat (20) @(negedge clk);
        rd(8'hf9, 8'h80);
        chk({7'h00, rst_oe_n}, 8'h01);
        $display("test soft reset done");
        sup_ready = 1'b0;
        sup_trip = 1'b1;
        repeat (3) @(negedge clk);
        rd(8'hf9, 8'h40);
        $display("test supply status done");
        report_and_stop();
    end
endmodule
bind svm_map svm_map_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES))
    i_svm_map_props (.clk(clk), .resetn(resetn), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .addr(addr), .wdata(wdata), .stop_cond(stop_cond),
    .nv_busy_reg(nv_busy_reg), .rdata_reg(rdata_reg),
    .rd_valid_reg(rd_valid_reg), .pullup_en_reg(pullup_en_reg),
    .pulldown_en_reg(pulldown_en_reg), .rst_out_reg(rst_out_reg),
    .rst_oe_n_reg(rst_oe_n_reg));
`default_nettype wire

// ==== dv/svm_pins.sv ====
// pad model: resolves the four i/o pin levels seen by the map
`timescale 1ns/1ps
`default_nettype none
module svm_pins
(
    input wire logic [3:0] pullup_en,
    input wire logic [3:0] pulldown_en,
    input wire logic [3:0] ext_drive,
    output logic [3:0] pin_level
);
    // strong pull-down wins over the weak pull-up
    always_comb
    begin
        pin_level = (ext_drive | pullup_en) & ~pulldown_en;
    end
endmodule
`default_nettype wire

// ==== rtl/svm_consts.vh ====
// address map, reset values and timing of the supervisor memory map
`ifndef SVM_CONSTS_VH
`define SVM_CONSTS_VH
`define SVM_EEP_BASE 8'h00
`define SVM_EEP_LAST 8'h3f
`define SVM_EEP_AW 6
`define SVM_RSV_FIRST 8'h40
`define SVM_RSV_LAST 8'hef
`define SVM_PULLUP_OFS 8'hf0
`define SVM_RSTDLY_OFS 8'hf1
`define SVM_USER0_OFS 8'hf2
`define SVM_USER1_OFS 8'hf3
`define SVM_PIN3_OFS 8'hf4
`define SVM_PIN2_OFS 8'hf5
`define SVM_PIN1_OFS 8'hf6
`define SVM_PIN0_OFS 8'hf7
`define SVM_STATUS_OFS 8'hf8
`define SVM_CONFIG_OFS 8'hf9
`define SVM_SRAM_FIRST 8'hfa
`define SVM_SRAM_LAST 8'hff
`define SVM_PULLUP_RST 8'h00
`define SVM_RSTDLY_RST 8'h03
`define SVM_USER_RST 8'h00
`define SVM_PINCTL_RST 8'h01
`define SVM_SRAM_RST 8'h00
`define SVM_CFG_READY_BIT 7
`define SVM_CFG_TRIP_BIT 6
`define SVM_CFG_RSTST_BIT 5
`define SVM_CFG_SHADOW_BIT 4
`define SVM_CFG_SOFTRST_BIT 3
`define SVM_CLK_HZ 20000000
`define SVM_NV_WRITE_MIN_MS 10
`define SVM_NV_WRITE_CYCLES (`SVM_NV_WRITE_MIN_MS * (`SVM_CLK_HZ / 1000))
`define SVM_SOFTRST_CYCLES 16
`endif

// ==== rtl/svm_eeprom.v ====
// 64-byte user nonvolatile array with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "svm_consts.vh"
module svm_eeprom
(
    input wire clk,
    input wire wr_en,
    input wire [`SVM_EEP_AW-1:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata_reg
);
    reg [7:0] mem [0:(1<<`SVM_EEP_AW)-1];
    integer i;
    // factory contents are all zeros
    initial
    begin
        for (i = 0; i < (1<<`SVM_EEP_AW); i = i + 1)
            mem[i] = 8'h00;
    end
    always @(posedge clk)
    begin
        if (wr_en)
            mem[addr] <= wdata;
        rdata_reg <= mem[addr];
    end
endmodule
`default_nettype wire

// ==== rtl/svm_map.v ====
// byte-wide register and memory map of the supervisor and i/o expander
// What this block does
// - 64 nonvolatile user bytes at 00h-3Fh
// - user array writes arm programming, except while a cycle runs
// - six volatile bytes FAh-FFh, zero at reset
// - shadowed user bytes F2h, F3h, reset zero
// - unused control bits stored and read back, except in F9
// - F0 bits 3..0 drive pin pull-ups
// - F1 bits 1..0 select reset delay
// - F8 returns live pin levels, upper zero
// - F9 holds ready, trip, status, shadow, reset
// - shadow select picks nonvolatile or volatile commit
// - programming starts at stop, lasts 10 ms
// - F4-F7 bit 0: zero enables the pin's pull-down, one disables it; pull-ups come from F0 only
// - soft reset asserts reset, then self-clears
`timescale 1ns/1ps
`default_nettype none
`include "svm_consts.vh"
module svm_map
#(
    parameter NV_WRITE_CYCLES = `SVM_NV_WRITE_CYCLES
)
(
    input wire clk,
    input wire resetn,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire stop_cond,
    input wire supply_ready,
    input wire supply_trip,
    input wire [3:0] gp_pin_in,
    output reg [7:0] rdata_reg,
    output reg rd_valid_reg,
    output reg nv_busy_reg,
    output reg [3:0] pullup_en_reg,
    output reg [3:0] pulldown_en_reg,
    output reg [1:0] reset_delay_sel_reg,
    output reg rst_out_reg,
    output reg rst_oe_n_reg
);
    reg [7:0] pullup_reg;
    reg [7:0] rstdly_reg;
    reg [7:0] user0_reg;
    reg [7:0] user1_reg;
    reg [7:0] pinctl_reg [0:3];
    reg [7:0] sram_reg [0:5];
    reg shadow_sel_reg;
    reg soft_reset_request_reg;
    reg [4:0] softrst_cnt_reg;
    reg nv_pending_reg;
    reg [31:0] nv_cnt_reg;
    reg [3:0] pin_s1_reg;
    reg [3:0] pin_s2_reg;
    reg [1:0] sup_s1_reg;
    reg [1:0] sup_s2_reg;
    reg rd_pend_reg;
    reg rd_eep_reg;
    reg [7:0] map_data_reg;
    reg [7:0] map_data_next;
    wire [7:0] eep_rdata;
    wire in_eep = (addr <= `SVM_EEP_LAST);
    wire in_shadow = (addr >= `SVM_PULLUP_OFS) && (addr <= `SVM_PIN0_OFS);
    wire in_sram = (addr >= `SVM_SRAM_FIRST);
    // writes are dropped while a programming cycle is running
    wire wr_ok = wr_stb && !nv_busy_reg;
    wire [2:0] sram_idx = addr[2:0] - 3'd2;
    wire [1:0] pin_idx = addr[1:0];
    wire reset_active = soft_reset_request_reg;
    integer k;

    svm_eeprom u_eep
    (
        .clk(clk),
        .wr_en(wr_ok && in_eep),
        .addr(addr[`SVM_EEP_AW-1:0]),
        .wdata(wdata),
        .rdata_reg(eep_rdata)
    );

    // status inputs come from outside the clock domain
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            sup_s1_reg <= 2'h0;
            sup_s2_reg <= 2'h0;
        end
        else
        begin
            pin_s1_reg <= gp_pin_in;
            pin_s2_reg <= pin_s1_reg;
            sup_s1_reg <= {supply_ready, supply_trip};
            sup_s2_reg <= sup_s1_reg;
        end
    end

    // register writes; unused upper bits are plain storage
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pullup_reg <= `SVM_PULLUP_RST;
            rstdly_reg <= `SVM_RSTDLY_RST;
            user0_reg <= `SVM_USER_RST;
            user1_reg <= `SVM_USER_RST;
            for (k = 0; k < 4; k = k + 1)
                pinctl_reg[k] <= `SVM_PINCTL_RST;
            for (k = 0; k < 6; k = k + 1)
                sram_reg[k] <= `SVM_SRAM_RST;
            shadow_sel_reg <= 1'b0;
        end
        else if (wr_ok)
        begin
            case (addr)
                `SVM_PULLUP_OFS: pullup_reg <= wdata;
                `SVM_RSTDLY_OFS: rstdly_reg <= wdata;
                `SVM_USER0_OFS: user0_reg <= wdata;
                `SVM_USER1_OFS: user1_reg <= wdata;
                `SVM_PIN3_OFS, `SVM_PIN2_OFS, `SVM_PIN1_OFS, `SVM_PIN0_OFS:
                    pinctl_reg[pin_idx] <= wdata;
                `SVM_CONFIG_OFS:
                    shadow_sel_reg <= wdata[`SVM_CFG_SHADOW_BIT];
                default:
                begin
                    if (in_sram)
                        sram_reg[sram_idx] <= wdata;
                end
            endcase
        end
    end

    // soft reset: a written one wins over the self-clear
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            soft_reset_request_reg <= 1'b0;
            softrst_cnt_reg <= 5'd0;
        end
        else if (wr_ok && addr == `SVM_CONFIG_OFS
                 && wdata[`SVM_CFG_SOFTRST_BIT])
        begin
            soft_reset_request_reg <= 1'b1;
            softrst_cnt_reg <= 5'd0;
        end
        else if (soft_reset_request_reg)
        begin
            if (softrst_cnt_reg == `SVM_SOFTRST_CYCLES - 1)
                soft_reset_request_reg <= 1'b0;
            softrst_cnt_reg <= softrst_cnt_reg + 5'd1;
        end
    end

    // programming timer, armed by the write, started by stop
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            nv_pending_reg <= 1'b0;
            nv_busy_reg <= 1'b0;
            nv_cnt_reg <= 32'd0;
        end
        else if (nv_busy_reg)
        begin
            if (nv_cnt_reg == NV_WRITE_CYCLES - 1)
                nv_busy_reg <= 1'b0;
            nv_cnt_reg <= nv_cnt_reg + 32'd1;
        end
        else
        begin
            if (wr_ok && (in_eep || (in_shadow && !shadow_sel_reg)))
                nv_pending_reg <= 1'b1;
            if (stop_cond && (nv_pending_reg || (wr_ok
                && (in_eep || (in_shadow && !shadow_sel_reg)))))
            begin
                nv_pending_reg <= 1'b0;
                nv_busy_reg <= 1'b1;
                nv_cnt_reg <= 32'd0;
            end
        end
    end

    always @*
    begin
        map_data_next = 8'h00;
        case (addr)
            `SVM_PULLUP_OFS: map_data_next = pullup_reg;
            `SVM_RSTDLY_OFS: map_data_next = rstdly_reg;
            `SVM_USER0_OFS: map_data_next = user0_reg;
            `SVM_USER1_OFS: map_data_next = user1_reg;
            `SVM_PIN3_OFS, `SVM_PIN2_OFS, `SVM_PIN1_OFS, `SVM_PIN0_OFS:
                map_data_next = pinctl_reg[pin_idx];
            `SVM_STATUS_OFS: map_data_next = {4'h0, pin_s2_reg};
            `SVM_CONFIG_OFS:
                map_data_next = {sup_s2_reg, reset_active,
                                 shadow_sel_reg, soft_reset_request_reg,
                                 3'b000};
            default:
            begin
                if (in_sram)
                    map_data_next = sram_reg[sram_idx];
            end
        endcase
    end

    // two-stage read so the array's registered output can be muxed
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_pend_reg <= 1'b0;
            rd_eep_reg <= 1'b0;
            map_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            rd_pend_reg <= rd_stb;
            rd_eep_reg <= in_eep;
            map_data_reg <= map_data_next;
            rd_valid_reg <= rd_pend_reg;
            if (rd_pend_reg)
                rdata_reg <= rd_eep_reg ? eep_rdata : map_data_reg;
        end
    end

    // pin controls and open-drain reset drive
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pullup_en_reg <= 4'h0;
            pulldown_en_reg <= 4'h0;
            reset_delay_sel_reg <= 2'b11;
            rst_out_reg <= 1'b0;
            rst_oe_n_reg <= 1'b1;
        end
        else
        begin
            pullup_en_reg <= pullup_reg[3:0];
            pulldown_en_reg <= ~{pinctl_reg[0][0], pinctl_reg[1][0],
                                 pinctl_reg[2][0], pinctl_reg[3][0]};
            reset_delay_sel_reg <= rstdly_reg[1:0];
            rst_out_reg <= 1'b0;
            rst_oe_n_reg <= ~reset_active;
        end
    end
endmodule
`default_nettype wire
